// ==== hw/slmif_pkg.sv ====
// constants, code tables and register map for the serial marker inserter and framer
package slmif_pkg;

  // ==========================================================================
  // register map (byte addresses) and control field layout
  localparam logic [3:0]  SLMIF_OFS_CTRL     = 4'h0;
  localparam logic [3:0]  SLMIF_OFS_STATUS   = 4'h4;
  localparam logic [3:0]  SLMIF_OFS_RXCHAR   = 4'h8;
  localparam int          SLMIF_CB_FIFO_N    = 0;
  localparam int          SLMIF_CB_CODEC_N   = 1;
  localparam int          SLMIF_CB_WIDTH8    = 2;
  localparam int          SLMIF_CB_SPEED     = 3;
  localparam int          SLMIF_CB_RANGE     = 4;
  localparam int          SLMIF_CB_FRAMER    = 5;
  localparam int          SLMIF_CB_KEEP_LO   = 6;
  localparam logic [7:0]  SLMIF_CTRL_RESET   = 8'h07;

  // ==========================================================================
  // timing and sizes
  localparam logic [1:0]  SLMIF_OVS_LAST     = 2'h3;   // four core cycles per line bit
  localparam logic [1:0]  SLMIF_OVS_SAMPLE   = 2'h2;   // mid-bit sample point
  localparam int          SLMIF_FIFO_DEPTH   = 16;
  localparam int          SLMIF_FIFO_AW      = 4;
  localparam logic [3:0]  SLMIF_LEN10        = 4'hA;
  localparam logic [3:0]  SLMIF_LEN12        = 4'hC;
  localparam logic [11:0] SLMIF_MULTI_ARM    = 12'h800;  // 2048 character clocks
  localparam logic [5:0]  SLMIF_SPAN_BITS    = 6'h32;    // 50-bit span for a comma pair
  localparam logic [5:0]  SLMIF_CHAR_BITS    = 6'h0A;
  localparam logic [3:0]  SLMIF_PH10_LAST    = 4'h9;

  // ==========================================================================
  // special characters as byte values (code group x.y packed as {y,x})
  localparam logic [7:0]  SLMIF_K23_7        = 8'hF7;    // cell marker
  localparam logic [7:0]  SLMIF_K27_7        = 8'hFB;    // expanded command marker
  localparam logic [7:0]  SLMIF_K29_7        = 8'hFD;    // serial address marker
  localparam logic [7:0]  SLMIF_K28_0        = 8'h1C;    // in-band rise
  localparam logic [7:0]  SLMIF_K28_3        = 8'h7C;    // in-band fall
  localparam logic [7:0]  SLMIF_K28_5        = 8'hBC;    // comma / fill
  localparam logic [9:0]  SLMIF_COMMA_NEG    = 10'h0FA;  // 0011111010
  localparam logic [9:0]  SLMIF_COMMA_POS    = 10'h305;  // 1100000101
  localparam logic [12:0] SLMIF_FILL12       = 13'h0C23; // 0110000100011
  localparam logic [1:0]  SLMIF_KEEP_ALL     = 2'h0;

  // ==========================================================================
  // 8b/10b sub-block tables, negative running disparity forms, bit a / f first
  localparam logic [5:0]  SLMIF_K28_6B       = 6'h0F;
  localparam logic [5:0]  SLMIF_D7_6B        = 6'h38;
  localparam logic [3:0]  SLMIF_X3_4B        = 4'hC;
  localparam logic [3:0]  SLMIF_A7_4B        = 4'h7;
  localparam logic [5:0]  SLMIF_TAB_6B [32]  = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
                                                6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
                                                6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
                                                6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0]  SLMIF_TAB_4B [8]   = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  // bit-clock multiplier, reported as twice the factor
  localparam logic [4:0]  SLMIF_MUL_W8 [3]   = '{5'h05, 5'h0A, 5'h14};
  localparam logic [4:0]  SLMIF_MUL_W10 [3]  = '{5'h06, 5'h0C, 5'h18};

endpackage

// ==== hw/slmif_core.sv ====
// marker inserter, serializer, deserializer, framer and decoder with register slave
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps

// What this block does
// - start only inserts cell marker before character
// - start plus special inserts expanded command marker
// - start, special, violation insert address marker
// - address field follows eight or ten width
// - in-band edge inserts character ahead, data waits
// - rising sends K28.0, falling sends K28.3
// - byte-packed mode packs ten-bit characters into bytes
// - packed mode carries ten-bit expanded commands
// - pre-encoded mode queues words, sends them raw
// - speed and range pick bit multiplier
// - pre-encoded uses in-band and halt as data
// - empty pre-encoded FIFO sends fill characters
// - recover bit timing, assemble ten or twelve bits
// - framer enabled realigns boundary on comma
// - framer disabled never moves the boundary
// - over 2048 enabled characters selects multi mode
// - multi mode needs two aligned commas within 50
// - decoded characters go straight to output register
// - empty flag shows kept or dropped comma
// - every decoded character checked against coding rules
// - output holds data, violation and control bits
// - in eight-bit width, special select picks the special code table
module slmif_core
  import slmif_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  // register slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // host transmit characters
  input  wire logic [9:0]  i_tx_char_bus,
  input  wire logic        i_tx_start_marker_in,
  input  wire logic        i_tx_special_select_n,
  input  wire logic        i_tx_violation_select,
  input  wire logic        i_tx_inband_signal_in,
  input  wire logic        i_tx_halt_in_n,
  input  wire logic        i_tx_stop_in_n,
  input  wire logic        i_tx_write_enable_n,
  output logic             o_tx_ready,
  // serial line
  output logic             o_tx_serial,
  input  wire logic        i_rx_serial,
  // host receive characters
  output logic      [11:0] o_rx_char_bus,
  output logic             o_rx_char_strobe,
  output logic             o_rx_char_clock,
  output logic             o_rx_empty_flag_n
);

  // ==========================================================================
  // coding functions
  function automatic logic [10:0] slmif_encode(input logic [7:0] b, input logic k, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic       rd6;
    logic       alt;
    s6 = (k && b[4:0] == SLMIF_K28_6B[4:0] + 5'h0D) ? SLMIF_K28_6B : SLMIF_TAB_6B[b[4:0]];
    if (rd && ($countones(s6) != 3 || s6 == SLMIF_D7_6B)) begin
      s6 = ~s6;
    end
    rd6 = ($countones(s6) != 3) ? ~rd : rd;
    alt = k || (!rd6 && (b[4:0] == 5'h11 || b[4:0] == 5'h12 || b[4:0] == 5'h14))
            || (rd6 && (b[4:0] == 5'h0B || b[4:0] == 5'h0D || b[4:0] == 5'h0E));
    s4 = (b[7:5] == 3'h7 && alt) ? SLMIF_A7_4B : SLMIF_TAB_4B[b[7:5]];
    if (rd6 ? ($countones(s4) != 2 || s4 == SLMIF_X3_4B) : (k && $countones(s4) == 2 && s4 != SLMIF_X3_4B)) begin
      s4 = ~s4;
    end
    return {(($countones(s4) != 2) ? ~rd6 : rd6), s6, s4};
  endfunction

  // returns {rd, violation, control, byte}
  function automatic logic [10:0] slmif_decode(input logic [9:0] c, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic [4:0] x;
    logic [2:0] y;
    logic       h6;
    logic       h4;
    logic       k;
    logic       bad;
    logic       rd6;
    s6 = c[9:4];
    s4 = (s6 == ~SLMIF_K28_6B && $countones(c[3:0]) == 2 && c[3:0] != SLMIF_X3_4B) ? ~c[3:0] : c[3:0];
    k = (s6 == SLMIF_K28_6B) || (s6 == ~SLMIF_K28_6B);
    x = k ? 5'h1C : 5'h00;
    y = 3'h0;
    h6 = k;
    h4 = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (s6 == SLMIF_TAB_6B[i] || (s6 == ~SLMIF_TAB_6B[i] &&
          ($countones(SLMIF_TAB_6B[i]) != 3 || SLMIF_TAB_6B[i] == SLMIF_D7_6B))) begin
        x = 5'(i);
        h6 = 1'b1;
      end
    end
    for (int j = 0; j < 8; j++) begin
      if (s4 == SLMIF_TAB_4B[j] || (s4 == ~SLMIF_TAB_4B[j] &&
          ($countones(SLMIF_TAB_4B[j]) != 2 || SLMIF_TAB_4B[j] == SLMIF_X3_4B))) begin
        y = 3'(j);
        h4 = 1'b1;
      end
    end
    if (s4 == SLMIF_A7_4B || s4 == ~SLMIF_A7_4B) begin
      y = 3'h7;
      h4 = 1'b1;
      k = k || x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E;
    end
    // a sub-block pushing disparity further the way it already leans is illegal
    bad = !h6 || !h4 || ($countones(s6) == 4 && rd) || ($countones(s6) == 2 && !rd);
    rd6 = ($countones(s6) == 4) ? 1'b1 : ($countones(s6) == 2) ? 1'b0 : rd;
    bad = bad || ($countones(s4) == 3 && rd6) || ($countones(s4) == 1 && !rd6);
    return {(($countones(s4) == 3) ? 1'b1 : ($countones(s4) == 1) ? 1'b0 : rd6), bad, k, y, x};
  endfunction

  // ==========================================================================
  // register slave: one wait state on every access
  logic [7:0]  ctrl_r;
  logic        ack_r;
  logic        multi_r;
  logic [11:0] rx_last_r;
  logic [4:0]  mul_code;
  logic        fifo_on;
  logic        enc_on;
  logic        w8;
  logic [1:0]  spd_idx;

  assign fifo_on = ctrl_r[SLMIF_CB_FIFO_N];
  assign enc_on  = ctrl_r[SLMIF_CB_CODEC_N];
  assign w8      = ctrl_r[SLMIF_CB_WIDTH8];
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;

  // multiplier choice from speed and range selects
  assign spd_idx  = ctrl_r[SLMIF_CB_SPEED] ? 2'h2 : {1'b0, ctrl_r[SLMIF_CB_RANGE]};
  assign mul_code = w8 ? SLMIF_MUL_W8[spd_idx] : SLMIF_MUL_W10[spd_idx];

  // access handshake
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (i_avs_read || i_avs_write) && !ack_r;
    end
  end

  // control writes take effect on the edge that releases the master
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ctrl_r <= SLMIF_CTRL_RESET;
    end else if (i_avs_write && ack_r && i_avs_address == SLMIF_OFS_CTRL && i_avs_byteenable[0]) begin
      ctrl_r <= i_avs_writedata[7:0];
    end
  end

  // read data is ready in the cycle waitrequest drops; unmapped reads return zero
  logic tx_full;
  logic tx_empty;
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack_r) begin
      unique case (i_avs_address)
        SLMIF_OFS_CTRL:   o_avs_readdata <= {24'h00_0000, ctrl_r};
        SLMIF_OFS_STATUS: o_avs_readdata <= {19'h0_0000, mul_code, 5'h00, tx_full, tx_empty, multi_r};
        SLMIF_OFS_RXCHAR: o_avs_readdata <= {20'h0_0000, rx_last_r};
        default:          o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // transmit FIFO: entry is {violation, start, special, halt, in-band, data}
  logic [14:0] fifo_mem [SLMIF_FIFO_DEPTH];
  logic [4:0]  wr_ptr_r;
  logic [4:0]  rd_ptr_r;
  logic [14:0] head;
  logic        push;
  logic        pop;

  assign tx_empty   = wr_ptr_r == rd_ptr_r;
  assign tx_full    = wr_ptr_r == {~rd_ptr_r[4], rd_ptr_r[3:0]};
  assign o_tx_ready = !tx_full;   // host must not write while this is low
  assign push       = !i_tx_write_enable_n && !tx_full;
  assign head       = fifo_mem[rd_ptr_r[SLMIF_FIFO_AW-1:0]];

  // every word is queued whatever the coding mode
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      fifo_mem[wr_ptr_r[SLMIF_FIFO_AW-1:0]] <= {i_tx_violation_select, i_tx_start_marker_in,
        i_tx_special_select_n, i_tx_halt_in_n, i_tx_inband_signal_in, i_tx_char_bus};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      wr_ptr_r <= 5'h00;
      rd_ptr_r <= 5'h00;
    end else begin
      wr_ptr_r <= wr_ptr_r + 5'(push);
      rd_ptr_r <= rd_ptr_r + 5'(pop);
    end
  end

  // ==========================================================================
  // in-band signal: asynchronous level, synchronised before edge detection
  logic inb_s1_r;
  logic inb_s2_r;
  logic inb_prev_r;
  logic inb_pend_r;
  logic inb_lvl_r;
  logic inb_take;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      inb_s1_r   <= 1'b0;
      inb_s2_r   <= 1'b0;
      inb_prev_r <= 1'b0;
      inb_pend_r <= 1'b0;
      inb_lvl_r  <= 1'b0;
    end else begin
      inb_s1_r   <= i_tx_inband_signal_in;
      inb_s2_r   <= inb_s1_r;
      inb_prev_r <= inb_s2_r;
      // a new edge wins over the slot that consumes the previous one
      if (inb_s2_r != inb_prev_r && enc_on) begin
        inb_pend_r <= 1'b1;
        inb_lvl_r  <= inb_s2_r;
      end else if (inb_take) begin
        inb_pend_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // character selection and packing accumulator
  logic [17:0] acc_r;
  logic [4:0]  cnt_r;
  logic        acc_k_r;
  logic        rd_r;
  logic [17:0] acc_nxt;
  logic [4:0]  cnt_nxt;
  logic        acc_k_nxt;
  logic        rd_nxt;
  logic [11:0] sym;
  logic [3:0]  sym_len;
  logic        slot;
  logic        have;
  logic [7:0]  sel_byte;
  logic        sel_k;
  logic [10:0] enc;
  logic [17:0] merged;
  logic [9:0]  src;
  logic [7:0]  marker;

  always_comb begin
    pop = 1'b0;
    inb_take = 1'b0;
    acc_nxt = acc_r;
    cnt_nxt = cnt_r;
    acc_k_nxt = acc_k_r;
    sel_byte = SLMIF_K28_5;
    sel_k = 1'b1;
    sym_len = SLMIF_LEN10;
    // halt is a data bit in pre-encoded modes, so it only gates encoded reads
    have = !tx_empty && i_tx_stop_in_n && (head[11] || !enc_on);
    src = w8 ? {2'b00, head[7:0]} : head[9:0];
    merged = acc_r | (18'(src) << cnt_r);
    marker = 8'h00;
    if (fifo_on && enc_on && head[13] && !head[14]) begin
      marker = head[12] ? SLMIF_K27_7 : SLMIF_K23_7;
    end else if (fifo_on && enc_on && head[13] && head[12]) begin
      marker = SLMIF_K29_7;
    end
    if (enc_on) begin
      if (inb_pend_r) begin
        inb_take = slot;
        sel_byte = inb_lvl_r ? SLMIF_K28_0 : SLMIF_K28_3;
      end else if (cnt_r >= 5'h08) begin
        sel_byte = acc_r[7:0];
        sel_k = acc_k_r;
        acc_nxt = acc_r >> 8;
        cnt_nxt = cnt_r - 5'h08;
      end else if (have) begin
        pop = slot;
        if (marker != 8'h00) begin
          sel_byte = marker;
          acc_nxt = merged;
          cnt_nxt = cnt_r + (w8 ? 5'h08 : 5'h0A);
          acc_k_nxt = 1'b0;
        end else begin
          sel_byte = merged[7:0];
          sel_k = w8 && head[12];
          acc_nxt = merged >> 8;
          cnt_nxt = cnt_r + (w8 ? 5'h00 : 5'h02);
        end
      end
    end
    enc = slmif_encode(sel_byte, sel_k, rd_r);
    sym = {enc[9:0], 2'b00};
    rd_nxt = enc[10];
    if (!enc_on) begin
      rd_nxt = rd_r;
      pop = slot && have;
      if (have && w8) begin
        sym = {{<<{head[11], head[10], head[7:0]}}, 2'b00};
      end else if (have) begin
        sym = {<<{head[9:8], head[11], head[10], head[7:0]}};
        sym_len = SLMIF_LEN12;
      end else if (w8) begin
        rd_nxt = enc[10];  // K28.5 alternates disparity on its own
      end else begin
        sym = SLMIF_FILL12[12:1];
        sym_len = SLMIF_LEN12;
      end
    end
  end

  // ==========================================================================
  // serializer: first bit of a symbol sits at the top of the shift register
  logic [11:0] tx_sh_r;
  logic [1:0]  tx_ovs_r;
  logic [3:0]  tx_bit_r;
  logic [3:0]  tx_len_r;

  assign slot = tx_ovs_r == SLMIF_OVS_LAST && tx_bit_r == tx_len_r - 4'h1;
  assign o_tx_serial = tx_sh_r[11];

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      tx_sh_r  <= 12'h000;
      tx_ovs_r <= 2'h0;
      tx_bit_r <= 4'h0;
      tx_len_r <= SLMIF_LEN10;
      acc_r    <= 18'h0_0000;
      cnt_r    <= 5'h00;
      acc_k_r  <= 1'b0;
      rd_r     <= 1'b0;
    end else begin
      tx_ovs_r <= tx_ovs_r + 2'h1;
      if (slot) begin
        tx_sh_r  <= sym;
        tx_len_r <= sym_len;
        tx_bit_r <= 4'h0;
        acc_r    <= acc_nxt;
        cnt_r    <= cnt_nxt;
        acc_k_r  <= acc_k_nxt;
        rd_r     <= rd_nxt;
      end else if (tx_ovs_r == SLMIF_OVS_LAST) begin
        tx_sh_r  <= {tx_sh_r[10:0], 1'b0};
        tx_bit_r <= tx_bit_r + 4'h1;
      end
    end
  end

  // ==========================================================================
  // receive bit recovery: sample phase restarts on every line transition
  logic        rx_s1_r;
  logic        rx_s2_r;
  logic        rx_prev_r;
  logic [1:0]  rx_ph_r;
  logic        strobe;
  logic [11:0] rx_sh_r;
  logic [11:0] rx_sh_nxt;
  logic [3:0]  rx_bit_r;
  logic [3:0]  rx_len;
  logic        comma;
  logic        realign;
  logic        done;

  assign strobe    = rx_ph_r == SLMIF_OVS_SAMPLE;
  assign rx_sh_nxt = {rx_sh_r[10:0], rx_s2_r};
  assign rx_len    = (!enc_on && !w8) ? SLMIF_LEN12 : SLMIF_LEN10;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      rx_s1_r   <= 1'b0;
      rx_s2_r   <= 1'b0;
      rx_prev_r <= 1'b0;
      rx_ph_r   <= 2'h0;
    end else begin
      rx_s1_r   <= i_rx_serial;
      rx_s2_r   <= rx_s1_r;
      rx_prev_r <= rx_s2_r;
      rx_ph_r   <= (rx_s2_r != rx_prev_r) ? 2'h0 : rx_ph_r + 2'h1;
    end
  end

  // ==========================================================================
  // framer: single comma, or an aligned pair once multi mode is armed
  logic [11:0] en_cnt_r;
  logic        cand_r;
  logic [5:0]  cand_age_r;
  logic [3:0]  cand_ph_r;
  logic        pair_ok;

  assign comma   = rx_sh_nxt[9:0] == SLMIF_COMMA_NEG || rx_sh_nxt[9:0] == SLMIF_COMMA_POS;
  assign pair_ok = cand_r && cand_ph_r == SLMIF_PH10_LAST
                   && cand_age_r < SLMIF_SPAN_BITS - SLMIF_CHAR_BITS;
  assign realign = strobe && comma && ctrl_r[SLMIF_CB_FRAMER] && (!multi_r || pair_ok);
  assign done    = strobe && (realign || rx_bit_r == rx_len - 4'h1);

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      rx_sh_r    <= 12'h000;
      rx_bit_r   <= 4'h0;
      cand_r     <= 1'b0;
      cand_age_r <= 6'h00;
      cand_ph_r  <= 4'h0;
    end else if (strobe) begin
      rx_sh_r    <= rx_sh_nxt;
      rx_bit_r   <= done ? 4'h0 : rx_bit_r + 4'h1;
      cand_age_r <= cand_age_r + 6'h01;
      cand_ph_r  <= (cand_ph_r == SLMIF_PH10_LAST) ? 4'h0 : cand_ph_r + 4'h1;
      if (cand_age_r >= SLMIF_SPAN_BITS) begin
        cand_r <= 1'b0;
      end
      // a comma that does not complete a pair starts a new candidate
      if (comma && multi_r && !pair_ok) begin
        cand_r     <= 1'b1;
        cand_age_r <= 6'h00;
        cand_ph_r  <= 4'h0;
      end else if (realign) begin
        cand_r <= 1'b0;
      end
    end
  end

  // multi mode arms after the framer has stayed enabled long enough
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      en_cnt_r <= 12'h000;
      multi_r  <= 1'b0;
    end else if (!ctrl_r[SLMIF_CB_FRAMER]) begin
      en_cnt_r <= 12'h000;
      multi_r  <= 1'b0;
    end else if (done) begin
      en_cnt_r <= (en_cnt_r == 12'hFFF) ? en_cnt_r : en_cnt_r + 12'h001;
      multi_r  <= en_cnt_r >= SLMIF_MULTI_ARM;
    end
  end

  // ==========================================================================
  // decoder and output register
  logic        rx_rd_r;
  logic [10:0] dec;
  logic [1:0]  keep;

  assign dec  = slmif_decode(rx_sh_nxt[9:0], rx_rd_r);
  assign keep = ctrl_r[SLMIF_CB_KEEP_LO+1:SLMIF_CB_KEEP_LO];

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_rx_char_bus     <= 12'h000;
      o_rx_empty_flag_n <= 1'b1;
      o_rx_char_strobe  <= 1'b0;
      o_rx_char_clock   <= 1'b0;
      rx_rd_r           <= 1'b0;
      rx_last_r         <= 12'h000;
    end else begin
      o_rx_char_strobe <= done;
      // character clock is the bit timing divided by the character length
      o_rx_char_clock  <= rx_bit_r < (rx_len >> 1);
      if (done && enc_on) begin
        o_rx_char_bus     <= {2'b00, dec[8], dec[9], dec[7:0]};
        rx_last_r         <= {2'b00, dec[8], dec[9], dec[7:0]};
        rx_rd_r           <= dec[10];
        o_rx_empty_flag_n <= !(dec[8] && dec[7:0] == SLMIF_K28_5 && keep != SLMIF_KEEP_ALL);
      end else if (done) begin
        o_rx_char_bus     <= (rx_len == SLMIF_LEN12) ? {<<{rx_sh_nxt}} : {2'b00, {<<{rx_sh_nxt[9:0]}}};
        rx_last_r         <= (rx_len == SLMIF_LEN12) ? {<<{rx_sh_nxt}} : {2'b00, {<<{rx_sh_nxt[9:0]}}};
        o_rx_empty_flag_n <= 1'b1;
      end
    end
  end

endmodule

// ==== test/slmif_line_model.sv ====
// line partner: far end that echoes the serial stream back
`timescale 1ns/100ps
module slmif_line_model (
  // clock
  input  wire logic i_core_clk,
  // serial line
  input  wire logic i_line_in,
  output logic      o_line_out
);
  logic [2:0] dly_r;
  // cable delay, so the receiver meets an arbitrary bit phase
  always_ff @(posedge i_core_clk) begin
    dly_r <= {dly_r[1:0], i_line_in};
  end
  assign o_line_out = dly_r[2];
endmodule

// ==== test/slmif_core_chk.sv ====
// bus, line and receive-output assertions for the marker inserter and framer
`timescale 1ns/100ps
module slmif_core_chk (
  // clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_resetn,
  // register bus
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // line and receive side
  input wire logic        o_tx_serial,
  input wire logic [11:0] o_rx_char_bus,
  input wire logic        o_rx_char_strobe,
  input wire logic        o_rx_empty_flag_n
);
  // ==========================================================================
  // one domain: one clock and one disable for all
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_req_wait;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_req_take;
    (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  endsequence
  property p_one_wait;
    s_req_wait |=> s_req_take;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest held past one cycle");
  property p_idle;
    !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest without a request");
  property p_unmapped;
    s_req_take and (i_avs_read && !(i_avs_address inside {4'h0, 4'h4, 4'h8})) |-> o_avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // four core clocks per line bit; a slip in the bit timer shows here
  property p_bit_time;
    $changed(o_tx_serial) |=> $stable(o_tx_serial) [*3];
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("line bit shorter than four clocks");
  property p_strobe_pulse;
    o_rx_char_strobe |=> !o_rx_char_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than one cycle");
  property p_bus_strobe;
    $changed(o_rx_char_bus) |-> o_rx_char_strobe;
  endproperty
  a_bus_strobe: assert property (p_bus_strobe) else $error("output bus moved without strobe");
  property p_comma_drop;
    !o_rx_empty_flag_n |-> {o_rx_char_bus[9], o_rx_char_bus[7:0]} == 9'h1BC;
  endproperty
  a_comma_drop: assert property (p_comma_drop) else $error("empty flag with a non comma");
  property p_empty_strobe;
    $fell(o_rx_empty_flag_n) |-> o_rx_char_strobe;
  endproperty
  a_empty_strobe: assert property (p_empty_strobe) else $error("empty flag apart from a character");
endmodule
bind slmif_core slmif_core_chk slmif_core_chk_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_tx_serial(o_tx_serial),
  .o_rx_char_bus(o_rx_char_bus), .o_rx_char_strobe(o_rx_char_strobe), .o_rx_empty_flag_n(o_rx_empty_flag_n));

// ==== test/slmif_core_test.sv ====
// testbench: registers, marker insertion and in-band codes through a line loopback
`timescale 1ns/100ps
module slmif_core_test;
  import slmif_pkg::*;
  // ==========================================================================
  // stimulus and observed signals
  logic        clk = 0;
  logic        rstn = 0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 0;
  logic        wr = 0;
  logic [31:0] wdata = 32'h0;
  logic [9:0]  txc = 10'h0;
  logic        st = 0;
  logic        spn = 0;
  logic        vs = 0;
  logic        inb = 0;
  logic        wen_n = 1;
  logic [31:0] rdata;
  logic        wreq;
  logic        ser_o;
  logic        ser_i;
  logic [11:0] rxb;
  logic        stb;
  logic        emp_n;
  logic [31:0] q;
  logic [9:0]  seen[$];
  logic [9:0]  exp_q[$];
  int          n;
  int          num_errors = 0;
  int          cmp_count = 0;
  always #20 clk = ~clk;
  slmif_core slmif_core_i (.i_core_clk(clk), .i_resetn(rstn), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_tx_char_bus(txc), .i_tx_start_marker_in(st), .i_tx_special_select_n(spn),
    .i_tx_violation_select(vs), .i_tx_inband_signal_in(inb), .i_tx_halt_in_n(1'b1), .i_tx_stop_in_n(1'b1),
    .i_tx_write_enable_n(wen_n), .o_tx_ready(), .o_tx_serial(ser_o), .i_rx_serial(ser_i),
    .o_rx_char_bus(rxb), .o_rx_char_strobe(stb), .o_rx_char_clock(), .o_rx_empty_flag_n(emp_n));
  slmif_line_model slmif_line_model_i (.i_core_clk(clk), .i_line_in(ser_o), .o_line_out(ser_i));
  // collect kept characters; dropped commas never enter the list
  always @(posedge clk) begin
    if (stb === 1'b1 && emp_n === 1'b1) begin
      seen.push_back(rxb[9:0]);
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic limit(input int k);
    if (k >= 4000) begin
      num_errors++;
      wrap_up();
    end
  endtask
  // one bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 4000);
    r = rdata;
    limit(k);
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  // queue one character; enable stays low between calls
  task automatic put(input logic [9:0] c, input logic s, input logic p, input logic v);
    txc <= c;
    st <= s;
    spn <= p;
    vs <= v;
    wen_n <= 0;
    @(posedge clk);
  endtask
  // wait for the expected characters, then compare
  task automatic wait_q();
    int k;
    k = 0;
    while (seen.size() < exp_q.size() && k < 4000) begin
      @(posedge clk);
      k++;
    end
    foreach (exp_q[i]) chk(seen[i], exp_q[i]);
    limit(k);
    seen.delete();
    exp_q.delete();
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    bus(0, SLMIF_OFS_CTRL, 32'h0, q);
    chk(q, {24'h0, SLMIF_CTRL_RESET});
    bus(0, 4'hC, 32'h0, q);
    chk(q, 32'h0);
    bus(1, SLMIF_OFS_CTRL, 32'h67, q);
    bus(0, SLMIF_OFS_CTRL, 32'h0, q);
    chk(q, 32'h67);
    // framer on, commas dropped: wait for the first dropped comma
    n = 0;
    while (!(stb === 1'b1 && emp_n === 1'b0) && n < 4000) begin
      @(posedge clk);
      n++;
    end
    limit(n);
    seen.delete();
    put(10'h05A, 1, 0, 0);
    put(10'h03C, 1, 1, 0);
    put(10'h0A5, 1, 1, 1);
    put(10'h07C, 0, 1, 0);
    put(10'h000, 0, 0, 0);
    wen_n <= 1;
    exp_q = '{{2'b10, SLMIF_K23_7}, 10'h05A, {2'b10, SLMIF_K27_7}, 10'h03C, {2'b10, SLMIF_K29_7}, 10'h0A5,
              {2'b10, SLMIF_K28_3}, 10'h000};
    wait_q();
    // in-band edge while a data character waits behind it
    inb <= 1;
    repeat (4) @(posedge clk);
    put(10'h011, 0, 0, 0);
    wen_n <= 1;
    exp_q = '{{2'b10, SLMIF_K28_0}, 10'h011};
    wait_q();
    inb <= 0;
    exp_q = '{{2'b10, SLMIF_K28_3}};
    wait_q();
    wrap_up();
  end
endmodule
